// File: rtl/lcdc_pkg.sv
// shared constants for the segment display command decoder
// assumes a single 100 MHz clock and a synchronous active-high reset
package lcdc_pkg;
   localparam logic [5:0] ADDR_UPPER      = 6'h1C;
   localparam int         RAM_WORDS       = 40;
   localparam int         PTR_W           = 6;
   localparam int         SUB_W           = 3;
   localparam int         CONT_BIT        = 7;
   localparam logic [1:0] OP_MODE         = 2'h2;
   localparam logic [3:0] OP_DEVSEL       = 4'hC;
   localparam logic [4:0] OP_BANK         = 5'h1E;
   localparam logic [3:0] OP_BLINK        = 4'hE;
   localparam int         MODE_LP_BIT     = 4;
   localparam int         MODE_EN_BIT     = 3;
   localparam int         MODE_BIAS_BIT   = 2;
   localparam int         BANK_IN_BIT     = 1;
   localparam int         BANK_OUT_BIT    = 0;
   localparam int         BLINK_AB_BIT    = 2;
   localparam logic [1:0] DRIVE_STATIC    = 2'h1;
   localparam logic [1:0] DRIVE_MUX2      = 2'h2;
   localparam logic [1:0] DRIVE_MUX3      = 2'h3;
   localparam logic [1:0] DRIVE_MUX4      = 2'h0;
   localparam logic [1:0] RST_DRIVE       = 2'h0;
   localparam int         BLINK_DIV_NORM  = 92160;
   localparam int         BLINK_DIV_SAVE  = 15360;
   localparam int         STRETCH_CYCLES  = 4;
   typedef enum logic [1:0] {
      LCDC_IDLE,
      LCDC_CMD,
      LCDC_DATA,
      LCDC_IGNORE
   } lcdc_state_t;
endpackage

// File: rtl/lcdc_skid.sv
// two-entry buffer for display bytes on their way to the ram port
// assumes the downstream may drop ready at any time
module lcdc_skid #(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic         reset,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   logic [W-1:0] mem_r [2];
   logic [W-1:0] mem_nxt [2];
   logic         wp_r, wp_nxt, rp_r, rp_nxt;
   logic [1:0]   cnt_r, cnt_nxt;
   logic         push, pop;

   assign in_ready  = (cnt_r != 2'h2);
   assign out_valid = (cnt_r != 2'h0);
   assign out_data  = mem_r[rp_r];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      mem_nxt = mem_r;
      wp_nxt  = wp_r;
      rp_nxt  = rp_r;
      cnt_nxt = cnt_r;
      if (push) begin
         mem_nxt[wp_r] = in_data;
         wp_nxt        = ~wp_r;
      end
      if (pop) begin
         rp_nxt = ~rp_r;
      end
      if (push && !pop) begin
         cnt_nxt = cnt_r + 2'h1;
      end else if (pop && !push) begin
         cnt_nxt = cnt_r - 2'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         wp_r  <= 1'b0;
         rp_r  <= 1'b0;
         cnt_r <= 2'h0;
      end else begin
         wp_r  <= wp_nxt;
         rp_r  <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
      mem_r <= mem_nxt;
   end

   no_overfill_a : assert property (@(posedge clk) disable iff (reset)
      cnt_r <= 2'h2)
      else $error("buffer accepted while full");
endmodule

// File: rtl/lcdc_blink.sv
// blink period divider: one-cycle toggle pulse per blink half-period
// assumes rate 0 means off; divisors are parameters so sims can shrink them
module lcdc_blink #(
   parameter int DIV_NORM = lcdc_pkg::BLINK_DIV_NORM,
   parameter int DIV_SAVE = lcdc_pkg::BLINK_DIV_SAVE
) (
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic [1:0] rate,
   input  wire logic       power_save,
   output logic            tick
);
   logic [20:0] cnt_r, cnt_nxt;
   logic [20:0] limit;
   logic        tick_nxt;

   always_comb begin
      // the divisor spans a whole blink period: toggle at half of it
      limit = power_save ? 21'(DIV_SAVE / 2) : 21'(DIV_NORM / 2);
      if (rate == 2'h2) begin
         limit = limit << 1;
      end else if (rate == 2'h3) begin
         limit = limit << 2;
      end
      tick_nxt = 1'b0;
      cnt_nxt  = cnt_r + 21'h1;
      if (rate == 2'h0) begin
         cnt_nxt = 21'h0;
      end else if (cnt_r >= limit - 21'h1) begin
         cnt_nxt  = 21'h0;
         tick_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         cnt_r <= 21'h0;
         tick  <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         tick  <= tick_nxt;
      end
   end
endmodule

// File: rtl/lcdc_decoder.sv
// command decoder of a segment display driver, slave side of a two-wire bus
// assumes a byte-level front end: start/stop pulses, byte_valid per byte
// with the first byte after start being address+rw; ack sampled by front end
module lcdc_decoder
   import lcdc_pkg::*;
#(
   parameter int DIV_NORM = lcdc_pkg::BLINK_DIV_NORM,
   parameter int DIV_SAVE = lcdc_pkg::BLINK_DIV_SAVE
) (
   input  wire logic                       clk,
   input  wire logic                       reset,
   input  wire logic                       slave_addr_lsb_pin,
   input  wire logic                       hw_subaddr_pin0,
   input  wire logic                       hw_subaddr_pin1,
   input  wire logic                       hw_subaddr_pin2,
   input  wire logic                       bus_start,
   input  wire logic                       bus_stop,
   input  wire logic                       byte_valid,
   input  wire logic [7:0]                 byte_data,
   output logic                            ack_r,
   output logic                            scl_hold_r,
   output logic                            ram_we_r,
   output logic [lcdc_pkg::PTR_W-1:0]      ram_addr_r,
   output logic [7:0]                      ram_data_r,
   output logic                            ram_row_hi_r,
   input  wire logic                       ram_ready,
   output logic                            power_saving_select,
   output logic                            display_en_r,
   output logic                            bias_half_r,
   output logic [1:0]                      drive_mode_r,
   output logic                            out_bank_r,
   output logic                            alt_bank_blink_en,
   output logic [1:0]                      blink_rate_field,
   output logic                            blank_r
);
   import lcdc_pkg::*;

   lcdc_state_t          state_r, state_nxt;
   logic [PTR_W-1:0]     ptr_r, ptr_nxt;
   logic [SUB_W-1:0]     sub_r, sub_nxt;
   logic                 ack_nxt;
   logic                 lp_nxt, en_nxt, bias_nxt, in_bank_r, in_bank_nxt;
   logic                 out_bank_nxt, ab_nxt, blank_nxt, phase_r, phase_nxt;
   logic [1:0]           drive_nxt, rate_nxt;
   logic [SUB_W-1:0]     hw_sub;
   logic                 small_mux, tick;
   logic                 buf_in_valid, buf_in_ready, buf_out_valid;
   logic [15:0]          buf_in_data, buf_out_data;
   logic                 hold_nxt;

   function automatic logic is_small_mux(input logic [1:0] m);
      return (m == DRIVE_STATIC) || (m == DRIVE_MUX2);
   endfunction

   assign hw_sub    = {hw_subaddr_pin2, hw_subaddr_pin1, hw_subaddr_pin0};
   assign small_mux = is_small_mux(drive_mode_r);

   always_comb begin
      state_nxt    = state_r;
      ptr_nxt      = ptr_r;
      sub_nxt      = sub_r;
      ack_nxt      = 1'b0;
      lp_nxt       = power_saving_select;
      en_nxt       = display_en_r;
      bias_nxt     = bias_half_r;
      drive_nxt    = drive_mode_r;
      in_bank_nxt  = in_bank_r;
      out_bank_nxt = out_bank_r;
      ab_nxt       = alt_bank_blink_en;
      rate_nxt     = blink_rate_field;
      buf_in_valid = 1'b0;
      buf_in_data  = {8'h00, byte_data};
      if (bus_start) begin
         state_nxt = LCDC_IDLE;
      end else if (bus_stop) begin
         state_nxt = LCDC_IGNORE;
      end else if (byte_valid) begin
         case (state_r)
            LCDC_IDLE: begin
               if (byte_data[7:2] == ADDR_UPPER
                   && byte_data[1] == slave_addr_lsb_pin
                   && !byte_data[0]) begin
                  state_nxt = LCDC_CMD;
                  ack_nxt   = 1'b1;
               end else begin
                  state_nxt = LCDC_IGNORE;
               end
            end
            LCDC_CMD: begin
               ack_nxt = 1'b1;
               if (!byte_data[CONT_BIT]) begin
                  state_nxt = LCDC_DATA;
               end
               if (byte_data[6:5] == OP_MODE) begin
                  lp_nxt    = byte_data[MODE_LP_BIT];
                  en_nxt    = byte_data[MODE_EN_BIT];
                  bias_nxt  = byte_data[MODE_BIAS_BIT];
                  drive_nxt = byte_data[1:0];
               end else if (!byte_data[6]) begin
                  ptr_nxt = byte_data[5:0];
               end else if (byte_data[6:3] == OP_DEVSEL) begin
                  sub_nxt = byte_data[2:0];
               end else if (byte_data[6:2] == OP_BANK) begin
                  if (small_mux) begin
                     in_bank_nxt  = byte_data[BANK_IN_BIT];
                     out_bank_nxt = byte_data[BANK_OUT_BIT];
                  end
               end else if (byte_data[6:3] == OP_BLINK) begin
                  ab_nxt   = byte_data[BLINK_AB_BIT];
                  rate_nxt = byte_data[1:0];
               end
            end
            LCDC_DATA: begin
               if (sub_r == hw_sub) begin
                  ack_nxt      = 1'b1;
                  buf_in_valid = 1'b1;
                  buf_in_data  = {1'b0, in_bank_r, ptr_r, byte_data};
               end
               // every device walks pointer and subaddress together
               if (ptr_r == PTR_W'(RAM_WORDS - 1)) begin
                  ptr_nxt = '0;
                  sub_nxt = sub_r + SUB_W'(1);
               end else begin
                  ptr_nxt = ptr_r + PTR_W'(1);
               end
            end
            default: state_nxt = LCDC_IGNORE;
         endcase
      end
   end

   // stretch the bus clock when the ram path backs up in power-saving;
   // the hold also covers the cycle after each push, since the full flag
   // reaches the pin a cycle late and a byte could slip in meanwhile
   always_comb begin
      hold_nxt = power_saving_select
                 && (!buf_in_ready || buf_in_valid);
   end

   // bank swap only meaningful where an alternate bank exists
   always_comb begin
      phase_nxt = phase_r;
      if (blink_rate_field == 2'h0) begin
         phase_nxt = 1'b0;
      end else if (tick) begin
         phase_nxt = ~phase_r;
      end
      blank_nxt = !display_en_r;
      if (alt_bank_blink_en && small_mux) begin
         blank_nxt = !display_en_r;
      end else if (phase_r) begin
         blank_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_r             <= LCDC_IGNORE;
         ptr_r               <= '0;
         sub_r               <= '0;
         ack_r               <= 1'b0;
         power_saving_select <= 1'b0;
         display_en_r        <= 1'b0;
         bias_half_r         <= 1'b0;
         drive_mode_r        <= RST_DRIVE;
         in_bank_r           <= 1'b0;
         out_bank_r          <= 1'b0;
         alt_bank_blink_en   <= 1'b0;
         blink_rate_field    <= 2'h0;
         phase_r             <= 1'b0;
         blank_r             <= 1'b1;
         scl_hold_r          <= 1'b0;
      end else begin
         state_r             <= state_nxt;
         ptr_r               <= ptr_nxt;
         sub_r               <= sub_nxt;
         ack_r               <= ack_nxt;
         power_saving_select <= lp_nxt;
         display_en_r        <= en_nxt;
         // bias is a don't-care in static drive; forced low there
         bias_half_r         <= bias_nxt
                                && (drive_nxt != DRIVE_STATIC);
         drive_mode_r        <= drive_nxt;
         in_bank_r           <= in_bank_nxt;
         out_bank_r          <= (alt_bank_blink_en && small_mux)
                                ? (out_bank_nxt ^ (tick && phase_nxt
                                   != phase_r)) : out_bank_nxt;
         alt_bank_blink_en   <= ab_nxt;
         blink_rate_field    <= rate_nxt;
         phase_r             <= phase_nxt;
         blank_r             <= blank_nxt;
         scl_hold_r          <= hold_nxt;
      end
   end

   lcdc_skid #(
      .W(16)
   ) u_buf (
      .clk       (clk),
      .reset     (reset),
      .in_valid  (buf_in_valid),
      .in_ready  (buf_in_ready),
      .in_data   (buf_in_data),
      .out_valid (buf_out_valid),
      .out_ready (ram_ready),
      .out_data  (buf_out_data)
   );

   always_ff @(posedge clk) begin
      if (reset) begin
         ram_we_r     <= 1'b0;
         ram_addr_r   <= '0;
         ram_data_r   <= 8'h00;
         ram_row_hi_r <= 1'b0;
      end else begin
         ram_we_r     <= buf_out_valid && ram_ready;
         // address and data stand after the strobe until the next write
         if (buf_out_valid && ram_ready) begin
            ram_addr_r   <= buf_out_data[13:8];
            ram_data_r   <= buf_out_data[7:0];
            ram_row_hi_r <= buf_out_data[14];
         end
      end
   end

   lcdc_blink #(
      .DIV_NORM (DIV_NORM),
      .DIV_SAVE (DIV_SAVE)
   ) u_blink (
      .clk        (clk),
      .reset      (reset),
      .rate       (blink_rate_field),
      .power_save (power_saving_select),
      .tick       (tick)
   );

   sequence addr_match_s;
      state_r == LCDC_IDLE && byte_valid && !bus_start && !bus_stop
      && byte_data[7:1] == {ADDR_UPPER, slave_addr_lsb_pin} && !byte_data[0];
   endsequence

   sequence data_byte_s;
      state_r == LCDC_DATA && byte_valid && !bus_start && !bus_stop;
   endsequence

   addr_ack_a : assert property (@(posedge clk) disable iff (reset)
      addr_match_s |=> ack_r && state_r == LCDC_CMD)
      else $error("matching address not acknowledged");
   addr_miss_a : assert property (@(posedge clk) disable iff (reset)
      state_r == LCDC_IDLE && byte_valid && !bus_start && !bus_stop
      && byte_data[1] != slave_addr_lsb_pin |=> !ack_r)
      else $error("wrong address acknowledged");
   ignore_hold_a : assert property (@(posedge clk) disable iff (reset)
      state_r == LCDC_IGNORE && !bus_start |=> !ack_r)
      else $error("ignored transfer acknowledged");
   cmd_ack_a : assert property (@(posedge clk) disable iff (reset)
      state_r == LCDC_CMD && byte_valid && !bus_start && !bus_stop
      |=> ack_r)
      else $error("command byte not acknowledged");
   cont_end_a : assert property (@(posedge clk) disable iff (reset)
      state_r == LCDC_CMD && byte_valid && !bus_start && !bus_stop
      && !byte_data[7] |=> state_r == LCDC_DATA)
      else $error("last command did not enter data");
   data_ack_a : assert property (@(posedge clk) disable iff (reset)
      state_r == LCDC_DATA && byte_valid && !bus_start && !bus_stop
      |=> ack_r == ($past(sub_r) == hw_sub))
      else $error("data acknowledge wrong subaddress");
   ptr_step_a : assert property (@(posedge clk) disable iff (reset)
      state_r == LCDC_DATA && byte_valid && !bus_start && !bus_stop
      && ptr_r < PTR_W'(RAM_WORDS - 1) |=> ptr_r == $past(ptr_r) + 1)
      else $error("pointer did not advance");
   bank_lock_a : assert property (@(posedge clk) disable iff (reset)
      !small_mux && state_r == LCDC_CMD && byte_valid
      && byte_data[6:2] == OP_BANK |=> $stable(in_bank_r))
      else $error("bank changed in high mux");
   data_room_a : assert property (@(posedge clk) disable iff (reset)
      data_byte_s ##0 (power_saving_select && sub_r == hw_sub)
      |-> buf_in_ready)
      else $error("display byte arrived while buffer full");
   ptr_wrap_a : assert property (@(posedge clk) disable iff (reset)
      data_byte_s ##0 (ptr_r == PTR_W'(RAM_WORDS - 1))
      |=> ptr_r == '0 && sub_r == $past(sub_r) + SUB_W'(1))
      else $error("pointer did not wrap into next subaddress");
   blink_off_a : assert property (@(posedge clk) disable iff (reset)
      blink_rate_field == 2'h0 && !phase_r
      |=> blank_r == !$past(display_en_r))
      else $error("display blanked with blinking off");
   mux_blink_a : assert property (@(posedge clk) disable iff (reset)
      !small_mux && phase_r |=> blank_r)
      else $error("high mux blink did not blank display");
endmodule

// File: tb/lcdc_master_model.sv
// byte-level two-wire master plus a ram write port that can stall
// assumes the bench calls the tasks from a single process
module lcdc_master_model (
   input  wire logic       clk,
   input  wire logic       stall,
   input  wire logic       scl_hold_r,
   input  wire logic       ack_r,
   output logic            bus_start,
   output logic            bus_stop,
   output logic            byte_valid,
   output logic [7:0]      byte_data,
   output logic            ram_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   assign ram_ready = ~stall;
   initial begin
      bus_start = 1'b0;
      bus_stop = 1'b0;
      byte_valid = 1'b0;
      byte_data = 8'h00;
   end
   task automatic start();
      @(posedge clk) bus_start <= 1'b1;
      @(posedge clk) bus_start <= 1'b0;
   endtask
   task automatic stop();
      @(posedge clk) bus_stop <= 1'b1;
      @(posedge clk) bus_stop <= 1'b0;
   endtask
   // a held clock keeps the next byte back, as a real master must wait
   task automatic send(input logic [7:0] b, output logic a);
      @(posedge clk);
      while (scl_hold_r === 1'b1) @(posedge clk);
      byte_valid <= 1'b1;
      byte_data <= b;
      @(posedge clk);
      byte_valid <= 1'b0;
      byte_data <= ~b;
      #1 a = ack_r;
   endtask
endmodule

// File: tb/tb_lcd_driver_i2c_command_decoder.sv
// self-checking bench for the display command decoder
// assumes the byte-level master model and shrunk blink divisors
module tb_lcd_driver_i2c_command_decoder;
   timeunit 1ns;
   timeprecision 1ps;
   import lcdc_pkg::*;
   logic clk = 1'b0, reset = 1'b1, sa = 1'b0, stall = 1'b0;
   logic [2:0] sub = 3'h0;
   logic bus_start, bus_stop, byte_valid, ack_r, scl_hold_r, ram_we_r;
   logic [7:0] byte_data, ram_data_r;
   logic [PTR_W-1:0] ram_addr_r;
   logic ram_row_hi_r, ram_ready, ps, den, bias, obank, ab, blank;
   logic [1:0] drive, rate;
   logic [13:0] wq[$];
   logic hold_seen = 1'b0;
   int err_total = 0, n_checks = 0, cyc = 0;
   always #5 clk = ~clk;
   lcdc_master_model m (.clk(clk), .stall(stall), .scl_hold_r(scl_hold_r),
      .ack_r(ack_r), .bus_start(bus_start), .bus_stop(bus_stop),
      .byte_valid(byte_valid), .byte_data(byte_data), .ram_ready(ram_ready));
   lcdc_decoder #(.DIV_NORM(8), .DIV_SAVE(4)) dut (.clk(clk), .reset(reset),
      .slave_addr_lsb_pin(sa), .hw_subaddr_pin0(sub[0]),
      .hw_subaddr_pin1(sub[1]), .hw_subaddr_pin2(sub[2]),
      .bus_start(bus_start), .bus_stop(bus_stop), .byte_valid(byte_valid),
      .byte_data(byte_data), .ack_r(ack_r), .scl_hold_r(scl_hold_r),
      .ram_we_r(ram_we_r), .ram_addr_r(ram_addr_r), .ram_data_r(ram_data_r),
      .ram_row_hi_r(ram_row_hi_r), .ram_ready(ram_ready),
      .power_saving_select(ps), .display_en_r(den), .bias_half_r(bias),
      .drive_mode_r(drive), .out_bank_r(obank), .alt_bank_blink_en(ab),
      .blink_rate_field(rate), .blank_r(blank));
   always @(posedge clk) begin
      cyc++;
      if (ram_we_r === 1'b1 && ram_ready === 1'b1)
         wq.push_back({ram_addr_r, ram_data_r});
      if (scl_hold_r === 1'b1)
         hold_seen = 1'b1;
      if (cyc == 30000) begin
         err_total++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(string what, logic [13:0] exp, logic [13:0] got);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic put(logic [7:0] b, logic ea);
      logic a;
      m.send(b, a);
      chk("ack", 14'(ea), 14'(a));
   endtask
   // one addressed transfer carrying two command bytes
   task automatic cfg(logic [7:0] c1, logic [7:0] c2);
      m.start();
      put(8'h70, 1'b1);
      put(c1, 1'b1);
      put(c2, 1'b1);
      m.stop();
      repeat (3) @(posedge clk);
   endtask
   // one display byte to ram address 0 of subaddress 0
   task automatic wr1(logic [7:0] d);
      m.start();
      put(8'h70, 1'b1);
      put(8'hE0, 1'b1);
      put(8'h00, 1'b1);
      put(d, 1'b1);
      m.stop();
      repeat (5) @(posedge clk);
      chk("row data", {6'd0, d}, {ram_addr_r, ram_data_r});
   endtask
   task automatic toggles(int n, output int nb, output int nk);
      logic pb, pk;
      nb = 0;
      nk = 0;
      pb = obank;
      pk = blank;
      repeat (n) begin
         @(posedge clk);
         #1;
         nb += int'(obank !== pb);
         nk += int'(blank !== pk);
         pb = obank;
         pk = blank;
      end
   endtask
   task automatic t_addr();
      m.start();
      put(8'h72, 1'b0);
      put(8'hCD, 1'b0);
      m.stop();
      m.start();
      put(8'h71, 1'b0);
      m.stop();
      chk("drive", 14'(RST_DRIVE), 14'(drive));
      @(posedge clk) sa <= 1'b1;
      m.start();
      put(8'h72, 1'b1);
      put(8'h00, 1'b1);
      m.stop();
      @(posedge clk) sa <= 1'b0;
   endtask
   task automatic t_mode();
      for (int i = 0; i < 4; i++) begin
         cfg(8'hCC | 8'(i), 8'h70);
         chk("drive", 14'(i), 14'(drive));
         chk("bias", 14'(i != 1), 14'(bias));
         chk("enable", 14'h1, 14'(den));
      end
   endtask
   task automatic t_data();
      cfg(8'hD2, 8'h70);
      chk("save", 14'h1, 14'(ps));
      chk("enable", 14'h0, 14'(den));
      wq.delete();
      hold_seen = 1'b0;
      @(posedge clk) stall <= 1'b1;
      fork
         begin
            repeat (60) @(posedge clk);
            stall <= 1'b0;
         end
      join_none
      m.start();
      put(8'h70, 1'b1);
      put(8'hA3, 1'b1);
      put(8'h60, 1'b1);
      for (int k = 0; k < 5; k++)
         put(8'h11 * 8'(k + 1), 1'b1);
      put(8'h99, 1'b0);
      m.stop();
      repeat (70) @(posedge clk);
      chk("hold", 14'h1, 14'(hold_seen));
      chk("writes", 14'd5, 14'(wq.size()));
      for (int k = 0; k < 5; k++)
         chk("word", {6'(35 + k), 8'h11 * 8'(k + 1)}, wq[k]);
      wq.delete();
      m.start();
      put(8'h70, 1'b1);
      put(8'hA7, 1'b1);
      put(8'h67, 1'b1);
      put(8'h5A, 1'b0);
      put(8'hA5, 1'b1);
      m.stop();
      repeat (10) @(posedge clk);
      chk("wrap", {6'd0, 8'hA5}, wq[0]);
   endtask
   task automatic t_bank();
      cfg(8'hCE, 8'h7B);
      wr1(8'h3C);
      chk("in bank", 14'h1, 14'(ram_row_hi_r));
      chk("out bank", 14'h1, 14'(obank));
      cfg(8'hCC, 8'h78);
      wr1(8'hC3);
      chk("in bank", 14'h1, 14'(ram_row_hi_r));
      chk("out bank", 14'h1, 14'(obank));
   endtask
   task automatic t_blink();
      int b1, k1, b2, k2;
      cfg(8'hCE, 8'h75);
      chk("ab", 14'h1, 14'(ab));
      chk("rate", 14'h1, 14'(rate));
      toggles(256, b1, k1);
      cfg(8'hCE, 8'h76);
      chk("rate", 14'h2, 14'(rate));
      toggles(256, b2, k2);
      chk("swap", 14'h1, 14'(b2 > 0 && b1 > b2));
      chk("blank", 14'h0, 14'(k1 + k2));
      cfg(8'hCC, 8'h77);
      chk("rate", 14'h3, 14'(rate));
      toggles(256, b1, k1);
      cfg(8'hDC, 8'h77);
      toggles(256, b2, k2);
      chk("whole", 14'h1, 14'(k1 > 0 && b1 == 0));
      chk("ratio", 14'h1, 14'(k2 > k1));
      cfg(8'hCC, 8'h70);
      toggles(100, b1, k1);
      chk("off", 14'h0, 14'(k1 + b1));
   endtask
   initial begin
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      t_addr();
      t_mode();
      t_data();
      t_bank();
      t_blink();
      end_of_test();
   end
endmodule
